// file: rtl/dbsb_pkg.sv
// Shared constants for the debug status and breakpoint link
package dbsb_pkg;
  // Command codes: value after masking out the don't-care bit, except HALT and RESUME, which keep bit 2 and must match exactly
  localparam logic [7:0] CMD_MASK_X2    = 8'hFB;
  localparam logic [7:0] CMD_ERASE      = 8'h10;
  localparam logic [7:0] CMD_WR_CONFIG  = 8'h19;
  localparam logic [7:0] CMD_RD_STATUS  = 8'h30;
  localparam logic [7:0] CMD_LOAD_BP    = 8'h3B;
  localparam logic [7:0] CMD_HALT       = 8'h44;
  localparam logic [7:0] CMD_RESUME     = 8'h4C;
  // Status byte bit positions
  localparam int ST_ERASE_DONE = 7;
  localparam int ST_IDLE       = 6;
  localparam int ST_HALTED     = 5;
  localparam int ST_PM0        = 4;
  localparam int ST_HALT_CAUSE = 3;
  localparam int ST_LOCKED     = 2;
  localparam int ST_OSC_OK     = 1;
  localparam int ST_STACK_OVF  = 0;
  // First breakpoint byte fields, then slot count, address width and other device constants
  localparam int BP_SLOT_HI = 4;
  localparam int BP_SLOT_LO = 3;
  localparam int BP_EN      = 2;
  localparam int BP_BANK_HI = 1;
  localparam int BP_SLOTS   = 4;
  localparam int BP_AW      = 18;
  localparam int CFG_INFO_PAGE = 0;
  localparam logic [7:0] STACK_TOP_ADDR = 8'hFF;
  localparam logic [1:0] PM_ACTIVE      = 2'h0;
  // Link timing: half period of the link clock in system clocks
  localparam int LINK_HALF_NS = 40;
  localparam int CLK_NS       = 5;
  localparam logic [4:0] LINK_HALF = 5'(LINK_HALF_NS / CLK_NS);
  // Host register offsets
  localparam logic [3:0] HR_CMD    = 4'h0;
  localparam logic [3:0] HR_ARG0   = 4'h1;
  localparam logic [3:0] HR_ARG1   = 4'h2;
  localparam logic [3:0] HR_ARG2   = 4'h3;
  localparam logic [3:0] HR_STATUS = 4'h4;
  localparam logic [3:0] HR_MASK   = 4'h5;
  localparam logic [3:0] HR_RESULT = 4'h6;
  localparam int HS_BUSY = 0;
  localparam int HS_DONE = 1;

  // Data bytes that follow a command on the link
  function automatic logic [1:0] cmd_args_f(input logic [7:0] cmd);
    logic [7:0] m;
    m = cmd & CMD_MASK_X2;
    if (m == CMD_LOAD_BP)
      return 2'h3;
    else if (m == CMD_WR_CONFIG)
      return 2'h1;
    else
      return 2'h0;
  endfunction : cmd_args_f
endpackage : dbsb_pkg

// file: rtl/dbsb_link_if.sv
// Two-wire debug link: host-made clock and shared data wire
`timescale 1ns/1ps
interface dbsb_link_if;
  logic dbg_clk;
  logic host_dd_o;
  logic host_dd_oe;
  logic dev_dd_o;
  logic dev_dd_oe;
  logic dd;
  // Weak pull-up when nobody drives
  assign dd = dev_dd_oe ? dev_dd_o : (host_dd_oe ? host_dd_o : 1'b1);
  modport host (output dbg_clk, output host_dd_o, output host_dd_oe,
                input dd);
  modport dev (input dbg_clk, output dev_dd_o, output dev_dd_oe,
               input dd);
endinterface : dbsb_link_if

// file: rtl/dbsb_device.sv
// Device end: debug status byte, breakpoints and command decoder
// Summary of operation
// - Status bit 7 is erase done
// - Status bit 6 is clock-gated idle
// - Status bit 4 set in power mode 0
// - Bit 5 halted, bit 3 last halt cause
// - Cause 0 halt command, 1 breakpoint
// - Status bit 2 mirrors debug lock
// - Bit 1 needs both oscillators settled
// - Bit 0 set on write to 0xFF
// - Four separately enabled breakpoint slots
// - Enabled slot match on address halts CPU
// - Host sends three breakpoint data bytes
// - Byte one: slot, enable, address 17-16
// - Bytes two, three: address 15-8, 7-0
// - Flash written only via injected instructions
// - Info page reachable only after selection
// - Breakpoint load code 0011 1x11
// - Status read code 0011 0x00
// - Config bit 0 selects info page
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
module dbsb_device (
  input  wire logic        clk,
  input  wire logic        reset,
  dbsb_link_if.dev         link,
  input  wire logic [17:0] cpu_addr,
  input  wire logic        cpu_addr_valid,
  input  wire logic        cpu_clock_gated_idle,
  input  wire logic [1:0]  power_mode,
  input  wire logic        debug_lock_bit,
  input  wire logic        crystal_osc_settled,
  input  wire logic        rc_osc_settled,
  input  wire logic        data_wr_en,
  input  wire logic [7:0]  data_wr_addr,
  input  wire logic        erase_busy,
  output logic             cpu_halt,
  output logic             erase_start,
  output logic             info_page_select
);
  typedef enum logic [1:0] {
    DS_CMD, DS_ARG, DS_OUT, DS_TAIL
  } dbsb_dstate_type;

  typedef struct packed {
    logic                            clk_s1;
    logic                            clk_s2;
    logic                            clk_s3;
    logic                            dd_s1;
    logic                            dd_s2;
    dbsb_dstate_type                 st;
    logic [7:0]                      sh;
    logic [2:0]                      bitn;
    logic [7:0]                      cmd;
    logic [1:0]                      args_left;
    logic [7:0]                      arg0;
    logic [7:0]                      arg1;
    logic                            dout;
    logic                            oe;
    logic                            halted;
    logic                            cause_bp;
    logic                            stack_ovf;
    logic                            info_page;
    logic                            erase_go;
    logic [dbsb_pkg::BP_SLOTS-1:0]   bp_en;
    logic [dbsb_pkg::BP_SLOTS-1:0][dbsb_pkg::BP_AW-1:0] bp_addr;
  } dbsb_dev_state_type;

  dbsb_dev_state_type cur_ff;
  dbsb_dev_state_type nxt_st;
  logic [dbsb_pkg::BP_SLOTS-1:0] bp_hit;
  logic [7:0]                    status_byte;

  // One comparator per slot
  genvar gi;
  generate
    for (gi = 0; gi < dbsb_pkg::BP_SLOTS; gi++) begin : g_bp
      assign bp_hit[gi] = cur_ff.bp_en[gi] && cpu_addr_valid &&
                          (cpu_addr == cur_ff.bp_addr[gi]);
    end
  endgenerate

  always_comb begin
    status_byte                          = 8'h00;
    status_byte[dbsb_pkg::ST_ERASE_DONE] = ~erase_busy;
    status_byte[dbsb_pkg::ST_IDLE]       = cpu_clock_gated_idle;
    status_byte[dbsb_pkg::ST_HALTED]     = cur_ff.halted;
    status_byte[dbsb_pkg::ST_PM0]        =
      (power_mode == dbsb_pkg::PM_ACTIVE);
    status_byte[dbsb_pkg::ST_HALT_CAUSE] = cur_ff.cause_bp;
    status_byte[dbsb_pkg::ST_LOCKED]     = debug_lock_bit;
    status_byte[dbsb_pkg::ST_OSC_OK]     =
      crystal_osc_settled & rc_osc_settled;
    status_byte[dbsb_pkg::ST_STACK_OVF]  = cur_ff.stack_ovf;
  end

  always_comb begin
    logic       rise;
    logic       fall;
    logic [7:0] byte_in;
    logic [1:0] slot;
    rise    = 1'b0;
    fall    = 1'b0;
    byte_in = 8'h00;
    slot    = 2'h0;
    nxt_st  = cur_ff;
    // First stage feeds only the second one
    nxt_st.clk_s1   = link.dbg_clk;
    nxt_st.clk_s2   = cur_ff.clk_s1;
    nxt_st.clk_s3   = cur_ff.clk_s2;
    nxt_st.dd_s1    = link.dd;
    nxt_st.dd_s2    = cur_ff.dd_s1;
    nxt_st.erase_go = 1'b0;
    rise = cur_ff.clk_s2 & ~cur_ff.clk_s3;
    fall = ~cur_ff.clk_s2 & cur_ff.clk_s3;
    byte_in = {cur_ff.sh[6:0], cur_ff.dd_s2};

    unique case (cur_ff.st)
      DS_CMD, DS_ARG: begin
        if (rise) begin
          nxt_st.sh   = byte_in;
          nxt_st.bitn = cur_ff.bitn + 3'h1;
          if (cur_ff.bitn == 3'h7 && cur_ff.st == DS_CMD) begin
            nxt_st.cmd       = byte_in;
            nxt_st.args_left = dbsb_pkg::cmd_args_f(byte_in);
            if (dbsb_pkg::cmd_args_f(byte_in) != 2'h0)
              nxt_st.st = DS_ARG;
            unique case (byte_in & dbsb_pkg::CMD_MASK_X2)
              dbsb_pkg::CMD_RD_STATUS: begin
                nxt_st.sh = status_byte;
                nxt_st.st = DS_OUT;
                // Cleared on report; a write the same cycle re-arms
                nxt_st.stack_ovf = 1'b0;
              end
              dbsb_pkg::CMD_ERASE: nxt_st.erase_go = 1'b1;
              dbsb_pkg::CMD_HALT & dbsb_pkg::CMD_MASK_X2: begin
                if (byte_in == dbsb_pkg::CMD_HALT) begin
                  nxt_st.halted   = 1'b1;
                  nxt_st.cause_bp = 1'b0;
                end
              end
              dbsb_pkg::CMD_RESUME & dbsb_pkg::CMD_MASK_X2: begin
                if (byte_in == dbsb_pkg::CMD_RESUME && cur_ff.halted)
                  nxt_st.halted = 1'b0;
              end
              default: ;
            endcase
          end else if (cur_ff.bitn == 3'h7) begin
            nxt_st.args_left = cur_ff.args_left - 2'h1;
            if (cur_ff.args_left == 2'h1)
              nxt_st.st = DS_CMD;
            if ((cur_ff.cmd & dbsb_pkg::CMD_MASK_X2) ==
                dbsb_pkg::CMD_WR_CONFIG) begin
              nxt_st.info_page = byte_in[dbsb_pkg::CFG_INFO_PAGE];
            end else if (cur_ff.args_left == 2'h3) begin
              nxt_st.arg0 = byte_in;
            end else if (cur_ff.args_left == 2'h2) begin
              nxt_st.arg1 = byte_in;
            end else begin
              // Bits 7-5 of the first byte are dropped here
              slot = cur_ff.arg0[dbsb_pkg::BP_SLOT_HI:dbsb_pkg::BP_SLOT_LO];
              nxt_st.bp_en[slot]   = cur_ff.arg0[dbsb_pkg::BP_EN];
              nxt_st.bp_addr[slot] = {cur_ff.arg0[dbsb_pkg::BP_BANK_HI:0],
                                      cur_ff.arg1, byte_in};
            end
          end
        end
      end
      DS_OUT: begin
        if (rise) begin
          nxt_st.oe   = 1'b1;
          nxt_st.dout = cur_ff.sh[7];
          nxt_st.sh   = {cur_ff.sh[6:0], 1'b0};
          nxt_st.bitn = cur_ff.bitn + 3'h1;
          if (cur_ff.bitn == 3'h7)
            nxt_st.st = DS_TAIL;
        end
      end
      DS_TAIL: begin
        // Hold the last bit through the high phase the host samples in
        if (fall) begin
          nxt_st.oe = 1'b0;
          nxt_st.st = DS_CMD;
        end
      end
    endcase

    if (|bp_hit && !cur_ff.halted) begin
      nxt_st.halted   = 1'b1;
      nxt_st.cause_bp = 1'b1;
    end
    if (data_wr_en && data_wr_addr == dbsb_pkg::STACK_TOP_ADDR)
      nxt_st.stack_ovf = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign link.dev_dd_o    = cur_ff.dout;
  assign link.dev_dd_oe   = cur_ff.oe;
  assign cpu_halt         = cur_ff.halted;
  assign erase_start      = cur_ff.erase_go;
  assign info_page_select = cur_ff.info_page;
endmodule : dbsb_device

// file: rtl/dbsb_host.sv
// Host end: drives the link from software registers
`timescale 1ns/1ps
module dbsb_host (
  input  wire logic       clk,
  input  wire logic       reset,
  dbsb_link_if.host       link,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [7:0]      rdata,
  output logic            irq
);
  typedef enum logic [1:0] {
    HS_IDLE, HS_SEND, HS_RECV, HS_GAP
  } dbsb_hstate_type;

  typedef struct packed {
    dbsb_hstate_type  st;
    logic [3:0][7:0]  tx;
    logic [1:0]       nbytes;
    logic [1:0]       bi;
    logic [2:0]       bitn;
    logic [4:0]       ph;
    logic             hi;
    logic             lclk;
    logic             dout;
    logic             oe;
    logic             rx_read;
    logic [7:0]       rsh;
    logic [7:0]       result;
    logic             done;
    logic             mask;
    logic             dd_s1;
    logic             dd_s2;
    logic [7:0]       rdat;
    logic             irq;
  } dbsb_host_state_type;

  dbsb_host_state_type cur_ff;
  dbsb_host_state_type nxt_st;

  always_comb begin
    logic half_end;
    logic bit_end;
    half_end = 1'b0;
    bit_end  = 1'b0;
    nxt_st   = cur_ff;
    nxt_st.dd_s1 = link.dd;
    nxt_st.dd_s2 = cur_ff.dd_s1;
    nxt_st.rdat  = 8'h00;

    if (wr && cur_ff.st == HS_IDLE) begin
      unique case (addr)
        dbsb_pkg::HR_ARG0: nxt_st.tx[1] = wdata;
        dbsb_pkg::HR_ARG1: nxt_st.tx[2] = wdata;
        dbsb_pkg::HR_ARG2: nxt_st.tx[3] = wdata;
        dbsb_pkg::HR_CMD: begin
          // Flash is only reached by commands the device decodes
          nxt_st.tx[0]   = wdata;
          nxt_st.nbytes  = dbsb_pkg::cmd_args_f(wdata);
          nxt_st.rx_read = (wdata & dbsb_pkg::CMD_MASK_X2) ==
                           dbsb_pkg::CMD_RD_STATUS;
          nxt_st.st      = HS_SEND;
          nxt_st.bi      = 2'h0;
          nxt_st.bitn    = 3'h0;
          nxt_st.ph      = 5'h0;
          nxt_st.hi      = 1'b0;
          nxt_st.oe      = 1'b1;
          nxt_st.dout    = wdata[7];
        end
        default: ;
      endcase
    end
    if (wr && addr == dbsb_pkg::HR_MASK)
      nxt_st.mask = wdata[dbsb_pkg::HS_DONE];

    if (rd) begin
      unique case (addr)
        dbsb_pkg::HR_STATUS: begin
          nxt_st.rdat[dbsb_pkg::HS_BUSY] = cur_ff.st != HS_IDLE;
          nxt_st.rdat[dbsb_pkg::HS_DONE] = cur_ff.done;
          nxt_st.done = 1'b0;
        end
        dbsb_pkg::HR_MASK:   nxt_st.rdat[dbsb_pkg::HS_DONE] = cur_ff.mask;
        dbsb_pkg::HR_RESULT: nxt_st.rdat = cur_ff.result;
        default: ;
      endcase
    end

    if (cur_ff.st != HS_IDLE) begin
      nxt_st.ph = cur_ff.ph + 5'h1;
      half_end  = cur_ff.ph == dbsb_pkg::LINK_HALF - 5'h1;
      bit_end   = half_end && cur_ff.hi;
      if (half_end) begin
        nxt_st.ph = 5'h0;
        nxt_st.hi = ~cur_ff.hi;
      end
    end

    unique case (cur_ff.st)
      HS_IDLE: ;
      HS_SEND, HS_RECV: begin
        nxt_st.lclk = nxt_st.hi;
        if (bit_end) begin
          nxt_st.bitn = cur_ff.bitn + 3'h1;
          // Sample late in the high phase, after the device has turned
          if (cur_ff.st == HS_RECV)
            nxt_st.rsh = {cur_ff.rsh[6:0], cur_ff.dd_s2};
          nxt_st.dout = cur_ff.tx[cur_ff.bi][3'h6 - cur_ff.bitn];
          if (cur_ff.bitn == 3'h7) begin
            nxt_st.bi   = cur_ff.bi + 2'h1;
            nxt_st.dout = cur_ff.tx[cur_ff.bi + 2'h1][7];
            if (cur_ff.st == HS_RECV) begin
              nxt_st.result = {cur_ff.rsh[6:0], cur_ff.dd_s2};
              nxt_st.st     = HS_GAP;
              nxt_st.oe     = 1'b0;
            end else if (cur_ff.bi == cur_ff.nbytes) begin
              nxt_st.oe = 1'b0;
              nxt_st.st = cur_ff.rx_read ? HS_RECV : HS_GAP;
            end
          end
        end
      end
      HS_GAP: begin
        // One idle bit time so the device lets go of the wire
        nxt_st.lclk = 1'b0;
        if (bit_end) begin
          nxt_st.st   = HS_IDLE;
          nxt_st.done = 1'b1;
        end
      end
    endcase
    nxt_st.irq = nxt_st.done & cur_ff.mask;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign link.dbg_clk    = cur_ff.lclk;
  assign link.host_dd_o  = cur_ff.dout;
  assign link.host_dd_oe = cur_ff.oe;
  assign rdata           = cur_ff.rdat;
  assign irq             = cur_ff.irq;
endmodule : dbsb_host

// file: sim/dbsb_chk_sva.sv
// Protocol checker for the debug link between host and device ends
`timescale 1ns/1ps
module dbsb_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic dbg_clk,
  input wire logic host_dd_o,
  input wire logic host_dd_oe,
  input wire logic dev_dd_o,
  input wire logic dev_dd_oe,
  input wire logic dd
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_oe_exclusive: assert property (!(host_dd_oe && dev_dd_oe))
    else $error("both ends drive the data wire");
  a_idle_after_reset: assert property (
    $fell(reset) |-> !dbg_clk && !host_dd_oe && !dev_dd_oe)
    else $error("link not idle after reset");
  a_clk_high_phase: assert property (
    $rose(dbg_clk) |-> dbg_clk [*8] ##1 !dbg_clk)
    else $error("link clock high phase not eight cycles");
  a_clk_low_phase: assert property (
    $fell(dbg_clk) |-> !dbg_clk [*8])
    else $error("link clock low phase too short");
  a_host_data_hold: assert property (
    dbg_clk && $past(dbg_clk) && host_dd_oe |-> $stable(host_dd_o))
    else $error("host data moved while link clock high");
  a_host_drive_start: assert property (
    $rose(host_dd_oe) |-> !dbg_clk)
    else $error("host began driving in high phase");
  a_dev_bit_edge: assert property (
    dev_dd_oe && $changed(dev_dd_o) |-> dbg_clk)
    else $error("device data moved in low phase");
  a_dev_drive_start: assert property (
    $rose(dev_dd_oe) |-> dbg_clk)
    else $error("device began driving in low phase");

  c_dev_answer: cover property ($rose(dev_dd_oe));
  c_dev_release: cover property ($fell(dev_dd_oe));
  c_host_frame: cover property ($rose(host_dd_oe));
  c_dev_low_bit: cover property (dev_dd_oe && !dd);
endmodule : dbsb_chk

// file: sim/debug_status_breakpoints_bench.sv
// Bench joining host and device ends over the debug link
`timescale 1ns/1ps
module debug_status_breakpoints_bench;
  logic        clk;
  logic        reset;
  logic [3:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        irq;
  logic [17:0] cpu_addr;
  logic        cpu_addr_valid;
  logic [6:0]  cond;
  logic        data_wr_en;
  logic [7:0]  data_wr_addr;
  logic        cpu_halt;
  logic        info_page_select;
  logic        erase_start;
  logic [31:0] wire_bits = 32'h0;
  int          wire_cnt = 0;
  int          frame_bits;
  int          erase_cnt = 0;
  int          errors;
  int          num_checks;

  dbsb_link_if lnk ();
  dbsb_host i_dbsb_host (.clk(clk), .reset(reset), .link(lnk.host),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .irq(irq));
  // Condition vector: erase busy, idle, power mode, lock, two osc flags
  dbsb_device i_dbsb_device (.clk(clk), .reset(reset), .link(lnk.dev),
    .cpu_addr(cpu_addr), .cpu_addr_valid(cpu_addr_valid),
    .cpu_clock_gated_idle(cond[5]), .power_mode(cond[4:3]),
    .debug_lock_bit(cond[2]), .crystal_osc_settled(cond[1]),
    .rc_osc_settled(cond[0]), .data_wr_en(data_wr_en),
    .data_wr_addr(data_wr_addr), .erase_busy(cond[6]),
    .cpu_halt(cpu_halt), .erase_start(erase_start),
    .info_page_select(info_page_select));
  dbsb_chk i_dbsb_chk (.clk(clk), .reset(reset), .dbg_clk(lnk.dbg_clk),
    .host_dd_o(lnk.host_dd_o), .host_dd_oe(lnk.host_dd_oe),
    .dev_dd_o(lnk.dev_dd_o), .dev_dd_oe(lnk.dev_dd_oe), .dd(lnk.dd));

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  // Host bits as the device sees them, one per rising link clock
  always @(posedge lnk.dbg_clk) begin
    if (lnk.host_dd_oe) begin
      wire_bits <= {wire_bits[30:0], lnk.dd};
      wire_cnt  <= wire_cnt + 1;
    end
  end

  // Erase requests seen, one per pulse
  always @(posedge clk) begin
    if (erase_start === 1'h1)
      erase_cnt <= erase_cnt + 1;
  end

  function automatic logic [7:0] exp_st(input logic h, input logic c,
                                        input logic o);
    return {~cond[6], cond[5], h, cond[4:3] == 2'h0, c, cond[2],
            cond[1] & cond[0], o};
  endfunction : exp_st

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask : wr_reg

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 chk(rdata, e);
  endtask : rd_chk

  // Arguments go first so the command finds them in place
  task automatic run_cmd(input logic [7:0] c, input logic [23:0] args,
                         input int n);
    int i;
    int n0;
    for (i = 0; i < n; i++)
      wr_reg(dbsb_pkg::HR_ARG0 + 4'(i), args[23 - 8 * i -: 8]);
    n0 = wire_cnt;
    wr_reg(dbsb_pkg::HR_CMD, c);
    i = 0;
    while (irq !== 1'h1 && i < 2000) begin
      @(posedge clk);
      i++;
    end
    if (i == 2000) begin
      errors++;
      print_verdict();
    end
    frame_bits = wire_cnt - n0;
    rd_chk(dbsb_pkg::HR_STATUS, 8'h02);
    @(posedge clk);
    #1 chk(irq, 1'h0);
  endtask : run_cmd

  task automatic st_chk(input logic h, input logic c, input logic o);
    run_cmd(dbsb_pkg::CMD_RD_STATUS, 24'h0, 0);
    rd_chk(dbsb_pkg::HR_RESULT, exp_st(h, c, o));
  endtask : st_chk

  task automatic probe(input logic [17:0] a, input logic e);
    @(posedge clk);
    cpu_addr       <= a;
    cpu_addr_valid <= 1'h1;
    @(posedge clk);
    cpu_addr_valid <= 1'h0;
    #1 chk(cpu_halt, e);
  endtask : probe

  task automatic t_status();
    logic [6:0] tbl [2] = '{7'h56, 7'h23};
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      cond <= tbl[k];
      // Second pass sets the don't-care bit of the command
      run_cmd(8'h30 | 8'(k * 4), 24'h0, 0);
      rd_chk(dbsb_pkg::HR_RESULT, exp_st('0, '0, '0));
    end
    $display("status test done");
  endtask : t_status

  task automatic t_stack();
    @(posedge clk);
    data_wr_en   <= 1'h1;
    data_wr_addr <= 8'hFE;
    @(posedge clk);
    data_wr_en <= 1'h0;
    // A neighbouring address must leave the flag alone
    st_chk(1'h0, 1'h0, 1'h0);
    @(posedge clk);
    data_wr_en   <= 1'h1;
    data_wr_addr <= 8'hFF;
    @(posedge clk);
    data_wr_en <= 1'h0;
    st_chk(1'h0, 1'h0, 1'h1);
    st_chk(1'h0, 1'h0, 1'h0);
    $display("stack test done");
  endtask : t_stack

  task automatic t_halt();
    logic seen;
    run_cmd(dbsb_pkg::CMD_HALT, 24'h0, 0);
    chk(cpu_halt, 1'h1);
    st_chk(1'h1, 1'h0, 1'h0);
    // Masked: completion must not reach the interrupt line
    wr_reg(dbsb_pkg::HR_MASK, 8'h00);
    wr_reg(dbsb_pkg::HR_CMD, dbsb_pkg::CMD_RESUME);
    rd_chk(dbsb_pkg::HR_STATUS, 8'h01);
    seen = 1'h0;
    repeat (300) begin
      @(posedge clk);
      seen |= irq;
    end
    chk(seen, 1'h0);
    rd_chk(dbsb_pkg::HR_STATUS, 8'h02);
    chk(cpu_halt, 1'h0);
    wr_reg(dbsb_pkg::HR_MASK, 8'h02);
    rd_chk(dbsb_pkg::HR_MASK, 8'h02);
    $display("halt test done");
  endtask : t_halt

  task automatic t_bp();
    run_cmd(8'h3F, 24'hEEBCCD, 3);
    chk(wire_bits, 32'h3FEEBCCD);
    chk(frame_bits, 32'h20);
    run_cmd(dbsb_pkg::CMD_LOAD_BP, 24'h150055, 3);
    run_cmd(dbsb_pkg::CMD_LOAD_BP, 24'h110055, 3);
    probe(18'h10055, 1'h0);
    probe(18'h0BCCD, 1'h0);
    probe(18'h2BCCD, 1'h1);
    st_chk(1'h1, 1'h1, 1'h0);
    run_cmd(dbsb_pkg::CMD_RESUME, 24'h0, 0);
    chk(cpu_halt, 1'h0);
    $display("breakpoint test done");
  endtask : t_bp

  task automatic t_cfg();
    run_cmd(8'h1D, 24'h010000, 1);
    chk(info_page_select, 1'h1);
    run_cmd(dbsb_pkg::CMD_WR_CONFIG, 24'hFE0000, 1);
    chk(info_page_select, 1'h0);
    rd_chk(4'hF, 8'h00);
    // Erase code with the don't-care bit set gives exactly one pulse
    run_cmd(8'h14, 24'h0, 0);
    chk(erase_cnt, 32'h1);
    $display("config test done");
  endtask : t_cfg

  initial begin
    reset = 1'h1;
    {wr, rd, cpu_addr_valid, data_wr_en} = 4'h0;
    {addr, wdata, cpu_addr, data_wr_addr} = '0;
    cond = 7'h23;
    errors = 0;
    num_checks = 0;
    repeat (6) @(posedge clk);
    reset <= 1'h0;
    wr_reg(dbsb_pkg::HR_MASK, 8'h02);
    t_status();
    t_stack();
    t_halt();
    t_bp();
    t_cfg();
    print_verdict();
  end
endmodule : debug_status_breakpoints_bench
